/* File: src/rcm_pkg.sv */
/*
   constants, register map and control layout of the receiver clock-mode and
   burst-detect block. assumes a 250 MHz aclk and AXI4-Lite register access.
*/
package rcm_pkg;
   localparam int CLK_HZ = 250_000_000;
   localparam int LOCK_TIME_MS = 15;
   localparam int LOCK_BASE_CYC = CLK_HZ / 1000 * LOCK_TIME_MS;
   localparam int LOCK_FRAMES_SLOW = 384;
   localparam int LOCK_FRAMES_FAST = 1;
   localparam int FRAMES_HOLD = 4096;
   localparam int HI_ON_HZ = 64000;
   localparam int HI_OFF_HZ = 54000;
   localparam int HI_ON_CYC = CLK_HZ / HI_ON_HZ;
   localparam int HI_OFF_CYC = CLK_HZ / HI_OFF_HZ;
   localparam int MAX_IVL_CYC = CLK_HZ / 7000;
   localparam logic [15:0] NPCM_SYNC_A = 16'hf872;
   localparam logic [15:0] NPCM_SYNC_B = 16'h4e1f;
   localparam int NPCM_ZERO_WORDS = 4;
   localparam int NUM_RATES = 13;
   localparam int RATE_HZ [NUM_RATES] = '{44100, 48000, 32000, 22050, 11025, 24000,
      16000, 88200, 8000, 96000, 64000, 176400, 192000};
   localparam logic [3:0] RATE_CODE [NUM_RATES] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5,
      4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'he};
   localparam logic [3:0] RATE_NONE = 4'h1;
   localparam logic [3:0] RATE_96K = 4'ha;
   localparam logic [3:0] RATE_192K = 4'he;
   localparam logic [1:0] REF_CHAN_STATUS = 2'b11;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_BURST = 8'h08;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      CM_PLL = 2'b00,
      CM_XTAL = 2'b01,
      CM_AUTO = 2'b10,
      CM_XTAL_MON = 2'b11
   } rcm_mode_t;

   typedef struct packed {
      logic dts_sixteen_bit_enable_en;
      logic dts_fourteen_bit_enable_en;
      logic quick_lock;
      logic [1:0] ref_sel;
      logic halve;
      logic xroute;
      logic [1:0] ratio;
      rcm_mode_t mode;
   } rcm_ctrl_t;

   localparam int CTRL_W = $bits(rcm_ctrl_t);
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h6c0;
endpackage : rcm_pkg

/* File: src/rcm_top.sv */
/*
   clock-source selection, master-clock generation, rate detection, lock
   tracking and non-PCM / DTS stream detection, with an AXI4-Lite slave.
   assumes received words, frame strobes and clock levels are synchronous
   to aclk; pll_clk and crystal_in are sampled 512fs-class clock levels.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module rcm_top
   import rcm_pkg::*;
#(
   parameter int LOCK_CYC = LOCK_BASE_CYC,
   parameter logic [31:0] DTS_SIXTEEN_BIT_ENABLE_SYNC = 32'h7ffe8001,
   parameter logic [31:0] DTS_FOURTEEN_BIT_ENABLE_SYNC = 32'h1fffe800
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic serial_mode,
   input wire logic [1:0] pin_clock_mode_sel,
   input wire logic [1:0] pin_ref_crystal_select,
   input wire logic [1:0] pin_ratio_sel,
   input wire logic [15:0] rx_word,
   input wire logic rx_word_valid,
   input wire logic rx_frame,
   input wire logic rx_data,
   input wire logic aux_data_in,
   input wire logic [3:0] cs_rate_code,
   input wire logic pll_clk,
   input wire logic crystal_in,
   output logic master_clock_out_a,
   output logic master_clock_out_b,
   output logic serial_data_out,
   output logic high_rate_indicator,
   output logic pll_unlocked,
   output logic pll_enable,
   output logic crystal_enable,
   output logic nonpcm_detected,
   output logic dts_stream_flag,
   output logic [3:0] rate_code
);
   ////////////////////////////////////////////////////////////////////////////
   // register slave
   rcm_ctrl_t ctrl_q, eff;
   logic [15:0] pc_q, pd_q;
   logic aw_have_q, w_have_q, use_xtal_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q, wr_img;
   logic [3:0] w_strb_q;
   logic do_wr, aw_hs, w_hs;

   assign aw_hs = awvalid && awready;
   assign w_hs = wvalid && wready;
   assign do_wr = aw_have_q && w_have_q && !bvalid;

   always_comb
   begin
      wr_img = {{(32-CTRL_W){1'b0}}, ctrl_q};
      for (int b = 0; b < 4; b++)
      begin
         if (w_strb_q[b])
         begin
            wr_img[8*b +: 8] = w_data_q[8*b +: 8];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         ctrl_q <= CTRL_RST;
      end
      else
      begin
         if (aw_hs)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (w_hs)
         begin
            w_have_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         awready <= !aw_have_q && !aw_hs && !bvalid && !do_wr;
         wready <= !w_have_q && !w_hs && !bvalid && !do_wr;
         if (do_wr)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= RESP_OKAY;
            if (aw_addr_q == OFS_CTRL)
            begin
               ctrl_q <= rcm_ctrl_t'(wr_img[CTRL_W-1:0]);
            end
            else if (aw_addr_q != OFS_STATUS && aw_addr_q != OFS_BURST)
            begin
               bresp <= RESP_SLVERR;
            end
         end
         else if (bvalid && bready)
         begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end
      else
      begin
         arready <= !rvalid && !(arvalid && arready);
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case (araddr)
               OFS_CTRL: rdata <= {{(32-CTRL_W){1'b0}}, ctrl_q};
               OFS_STATUS: rdata <= {22'h0, crystal_enable, use_xtal_q, pll_unlocked,
                  high_rate_indicator, dts_stream_flag, nonpcm_detected, rate_code};
               OFS_BURST: rdata <= {pd_q, pc_q};
               default:
               begin
                  rdata <= 32'h0;
                  rresp <= RESP_SLVERR;
               end
            endcase
         end
         else if (rvalid && rready)
         begin
            rvalid <= 1'b0;
         end
      end
   end

   // pin control overrides the register settings
   always_comb
   begin
      eff = ctrl_q;
      if (!serial_mode)
      begin
         eff.mode = rcm_mode_t'(pin_clock_mode_sel);
         eff.ref_sel = pin_ref_crystal_select;
         eff.ratio = pin_ratio_sel;
         eff.quick_lock = 1'b1;
         eff.dts_fourteen_bit_enable_en = 1'b1;
         eff.dts_sixteen_bit_enable_en = 1'b1;
         eff.xroute = 1'b0;
         eff.halve = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stream detection
   logic [16*(NPCM_ZERO_WORDS+2)-1:0] hist_q;
   logic [1:0] burst_cnt_q;
   logic [12:0] npcm_frames_q, dts_frames_q;
   logic npcm_hit, dts_hit;

   assign npcm_hit = rx_word_valid && rx_word == NPCM_SYNC_B
      && hist_q[15:0] == NPCM_SYNC_A && hist_q[16*(NPCM_ZERO_WORDS+1)-1:16] == '0;
   assign dts_hit = rx_word_valid
      && ((eff.dts_sixteen_bit_enable_en && {hist_q[15:0], rx_word} == DTS_SIXTEEN_BIT_ENABLE_SYNC)
      || (eff.dts_fourteen_bit_enable_en && {hist_q[15:0], rx_word} == DTS_FOURTEEN_BIT_ENABLE_SYNC));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hist_q <= '0;
         burst_cnt_q <= 2'd0;
         pc_q <= 16'h0;
         pd_q <= 16'h0;
      end
      else if (rx_word_valid)
      begin
         hist_q <= {hist_q[16*(NPCM_ZERO_WORDS+1)-1:0], rx_word};
         if (npcm_hit)
         begin
            burst_cnt_q <= 2'd2;
         end
         else if (burst_cnt_q == 2'd2)
         begin
            pc_q <= rx_word;
            burst_cnt_q <= 2'd1;
         end
         else if (burst_cnt_q == 2'd1)
         begin
            pd_q <= rx_word;
            burst_cnt_q <= 2'd0;
         end
      end
   end

   // detection wins over the quiet-frame timeout in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         nonpcm_detected <= 1'b0;
         npcm_frames_q <= 13'd0;
      end
      else if (npcm_hit)
      begin
         nonpcm_detected <= 1'b1;
         npcm_frames_q <= 13'd0;
      end
      else if (nonpcm_detected && rx_frame)
      begin
         if (npcm_frames_q == 13'(FRAMES_HOLD - 1))
         begin
            nonpcm_detected <= 1'b0;
            npcm_frames_q <= 13'd0;
         end
         else
         begin
            npcm_frames_q <= npcm_frames_q + 13'd1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dts_stream_flag <= 1'b0;
         dts_frames_q <= 13'd0;
      end
      else if (dts_hit)
      begin
         dts_stream_flag <= 1'b1;
         dts_frames_q <= 13'd0;
      end
      else if (dts_stream_flag && rx_frame)
      begin
         if (dts_frames_q == 13'(FRAMES_HOLD - 1))
         begin
            dts_stream_flag <= 1'b0;
            dts_frames_q <= 13'd0;
         end
         else
         begin
            dts_frames_q <= dts_frames_q + 13'd1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interval, lock and rate
   logic [15:0] ivl_cnt_q, ivl_q, ivl_diff;
   logic [21:0] lock_cnt_q;
   logic [8:0] lock_frm_q;
   logic [NUM_RATES-1:0] rate_hit;
   logic [3:0] meas_code;
   logic ivl_bad;

   assign ivl_diff = (ivl_cnt_q > ivl_q) ? ivl_cnt_q - ivl_q : ivl_q - ivl_cnt_q;
   assign ivl_bad = (rx_frame && ivl_diff > (ivl_q >> 5))
      || ivl_cnt_q >= 16'(MAX_IVL_CYC);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ivl_cnt_q <= 16'd0;
         ivl_q <= 16'd0;
      end
      else if (rx_frame)
      begin
         ivl_cnt_q <= 16'd1;
         ivl_q <= ivl_cnt_q;
      end
      else if (ivl_cnt_q != 16'hffff)
      begin
         ivl_cnt_q <= ivl_cnt_q + 16'd1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pll_unlocked <= 1'b1;
         lock_cnt_q <= 22'd0;
         lock_frm_q <= 9'd0;
      end
      else if (!pll_enable || ivl_bad)
      begin
         pll_unlocked <= 1'b1;
         lock_cnt_q <= 22'd0;
         lock_frm_q <= 9'd0;
      end
      else if (pll_unlocked)
      begin
         if (lock_cnt_q != 22'(LOCK_CYC))
         begin
            lock_cnt_q <= lock_cnt_q + 22'd1;
         end
         if (rx_frame && lock_frm_q != 9'(LOCK_FRAMES_SLOW))
         begin
            lock_frm_q <= lock_frm_q + 9'd1;
         end
         if (lock_cnt_q == 22'(LOCK_CYC) && lock_frm_q >= (eff.quick_lock ?
            9'(LOCK_FRAMES_FAST) : 9'(LOCK_FRAMES_SLOW)))
         begin
            pll_unlocked <= 1'b0;
         end
      end
   end

   for (genvar i = 0; i < NUM_RATES; i++)
   begin : g_rate
      localparam int NOM = CLK_HZ / RATE_HZ[i];
      assign rate_hit[i] = ivl_q >= 16'(NOM - NOM / 32) && ivl_q <= 16'(NOM + NOM / 32);
   end

   always_comb
   begin
      meas_code = RATE_NONE;
      for (int i = 0; i < NUM_RATES; i++)
      begin
         if (rate_hit[i])
         begin
            meas_code = RATE_CODE[i];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rate_code <= RATE_NONE;
         high_rate_indicator <= 1'b0;
      end
      else
      begin
         if (serial_mode && eff.ref_sel == REF_CHAN_STATUS)
         begin
            rate_code <= cs_rate_code;
         end
         else
         begin
            rate_code <= meas_code;
         end
         if (!pll_unlocked && ivl_q < 16'(HI_ON_CYC))
         begin
            high_rate_indicator <= 1'b1;
         end
         else if (!pll_unlocked && ivl_q > 16'(HI_OFF_CYC))
         begin
            high_rate_indicator <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock modes and master clocks
   logic use_xtal_d, pll_lvl_q, xtal_lvl_q, sw_hold_q, deny_a;
   logic [2:0] pll_div_q, xtal_div_q;
   logic mclk_a_d, mclk_b_d, src_a, src_b, xtal_a;

   always_comb
   begin
      case (eff.mode)
         CM_PLL: use_xtal_d = 1'b0;
         CM_XTAL: use_xtal_d = 1'b1;
         CM_AUTO: use_xtal_d = pll_unlocked;
         CM_XTAL_MON: use_xtal_d = 1'b1;
         default: use_xtal_d = 1'b1;
      endcase
   end

   // new source taken only while its level is low; dividers restart there
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         use_xtal_q <= 1'b0;
         sw_hold_q <= 1'b0;
         pll_lvl_q <= 1'b0;
         xtal_lvl_q <= 1'b0;
         pll_div_q <= 3'd0;
         xtal_div_q <= 3'd0;
      end
      else
      begin
         pll_lvl_q <= pll_clk;
         xtal_lvl_q <= crystal_in;
         sw_hold_q <= use_xtal_d != use_xtal_q;
         if (sw_hold_q && use_xtal_d != use_xtal_q
            && !(use_xtal_d ? crystal_in : pll_clk))
         begin
            use_xtal_q <= use_xtal_d;
            pll_div_q <= 3'd0;
            xtal_div_q <= 3'd0;
         end
         else
         begin
            if (pll_clk && !pll_lvl_q)
            begin
               pll_div_q <= pll_div_q + 3'd1;
            end
            if (crystal_in && !xtal_lvl_q)
            begin
               xtal_div_q <= xtal_div_q + 3'd1;
            end
         end
      end
   end

   assign deny_a = (eff.ratio == 2'b10 && (rate_code == RATE_96K || rate_code == RATE_192K))
      || (eff.ratio[1] == 1'b0 && rate_code == RATE_192K);

   always_comb
   begin
      src_a = use_xtal_q ? xtal_lvl_q : pll_lvl_q;
      xtal_a = xtal_div_q[0];
      case (eff.ratio)
         2'b10: mclk_a_d = src_a;
         2'b11: mclk_a_d = use_xtal_q ? xtal_div_q[1] : pll_div_q[1];
         default: mclk_a_d = use_xtal_q ? xtal_div_q[0] : pll_div_q[0];
      endcase
      case (eff.ratio)
         2'b01: src_b = xtal_div_q[1];
         2'b11: src_b = xtal_div_q[2];
         default: src_b = xtal_a;
      endcase
      if (eff.xroute)
      begin
         mclk_b_d = eff.halve ? xtal_div_q[0] : xtal_lvl_q;
      end
      else
      begin
         mclk_b_d = use_xtal_q ? src_b : 1'b0;
      end
      if (sw_hold_q || deny_a)
      begin
         mclk_a_d = 1'b0;
      end
      if (sw_hold_q && !eff.xroute)
      begin
         mclk_b_d = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         master_clock_out_a <= 1'b0;
         master_clock_out_b <= 1'b0;
         serial_data_out <= 1'b0;
         pll_enable <= 1'b0;
         crystal_enable <= 1'b0;
      end
      else
      begin
         master_clock_out_a <= mclk_a_d;
         master_clock_out_b <= mclk_b_d;
         serial_data_out <= use_xtal_q ? aux_data_in : rx_data;
         pll_enable <= eff.mode != CM_XTAL;
         crystal_enable <= !(eff.mode == CM_PLL && eff.ref_sel == REF_CHAN_STATUS);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // first valid word after the sync pair
   sequence s_burst_words;
      rx_word_valid && burst_cnt_q == 2'd2 && !npcm_hit;
   endsequence
   property p_npcm_set;
      @(posedge aclk) disable iff (!aresetn) npcm_hit |=> nonpcm_detected;
   endproperty
   a_npcm_set: assert property (p_npcm_set) else $error("non-PCM flag not set");
   property p_npcm_hold;
      @(posedge aclk) disable iff (!aresetn)
         nonpcm_detected && npcm_frames_q < 13'(FRAMES_HOLD - 1) |=> nonpcm_detected;
   endproperty
   a_npcm_hold: assert property (p_npcm_hold) else $error("non-PCM flag dropped early");
   property p_pc_capture;
      @(posedge aclk) disable iff (!aresetn) s_burst_words |=> pc_q == $past(rx_word);
   endproperty
   a_pc_capture: assert property (p_pc_capture) else $error("Pc not captured");
   property p_dts_clear;
      @(posedge aclk) disable iff (!aresetn)
         dts_stream_flag && rx_frame && !dts_hit && dts_frames_q == 13'(FRAMES_HOLD - 1)
         |=> !dts_stream_flag;
   endproperty
   a_dts_clear: assert property (p_dts_clear) else $error("DTS flag not cleared");
   property p_quick_pin;
      @(posedge aclk) disable iff (!aresetn) !serial_mode |-> eff.quick_lock;
   endproperty
   a_quick_pin: assert property (p_quick_pin) else $error("quick lock not forced");
   property p_unlock;
      @(posedge aclk) disable iff (!aresetn) ivl_bad |=> pll_unlocked;
   endproperty
   a_unlock: assert property (p_unlock) else $error("bad interval kept lock");
   property p_b_low_pll;
      @(posedge aclk) disable iff (!aresetn)
         !use_xtal_q && !eff.xroute |=> !master_clock_out_b;
   endproperty
   a_b_low_pll: assert property (p_b_low_pll) else $error("clock b runs under PLL");
   property p_mode1;
      @(posedge aclk) disable iff (!aresetn)
         eff.mode == CM_XTAL ##1 eff.mode == CM_XTAL |-> !pll_enable ##[1:8] use_xtal_q;
   endproperty
   a_mode1: assert property (p_mode1) else $error("mode 1 source wrong");
   property p_xtal_off;
      @(posedge aclk) disable iff (!aresetn)
         eff.mode == CM_PLL && eff.ref_sel == REF_CHAN_STATUS |=> !crystal_enable;
   endproperty
   a_xtal_off: assert property (p_xtal_off) else $error("crystal left running");
endmodule : rcm_top
`default_nettype wire

/* File: tb/rcm_tx_model.sv */
/*
   behavioural audio transmitter: frame strobes, received words and the
   recovered clock level. assumes everything runs on aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module rcm_tx_model
(
   input wire logic aclk,
   input wire logic [15:0] frame_cyc,
   output logic [15:0] rx_word,
   output logic rx_word_valid,
   output logic rx_frame,
   output logic rx_data,
   output logic pll_clk
);
   logic [15:0] cnt;
   initial
   begin
      cnt = 16'h0000;
      rx_word = 16'hffff;
      rx_word_valid = 1'b0;
      rx_frame = 1'b0;
      rx_data = 1'b0;
      pll_clk = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk)
   begin
      cnt <= (cnt >= frame_cyc - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
      rx_frame <= (cnt == 16'h0000);
      pll_clk <= ~pll_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // word not valid: show the inverse, never a stale copy
   task send_word(input logic [15:0] w);
      @(posedge aclk);
      rx_word <= w;
      rx_word_valid <= 1'b1;
      @(posedge aclk);
      rx_word <= ~w;
      rx_word_valid <= 1'b0;
   endtask : send_word
endmodule : rcm_tx_model
`default_nettype wire

/* File: tb/testbench.sv */
/*
   self-checking bench for rcm_top with a transmitter model.
   assumes 250 MHz aclk and a short lock count.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import rcm_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, serial_mode, aux;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic [1:0] pin_cm, pin_ref, pin_ratio, xd;
   logic [15:0] frame_cyc, rx_word;
   logic awready, wready, bvalid, arready, rvalid, rx_word_valid, rx_frame, rx_data;
   logic pll_clk, mca, mcb, sdo, hri, unl, pll_en, xtal_en, npcm, dts;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] rate, cs;
   int n_mismatch, samples_checked, cyc, ca, cb;
   logic pa, pb;
   rcm_top #(.LOCK_CYC(200), .DTS_SIXTEEN_BIT_ENABLE_SYNC(32'h7ffe8001), .DTS_FOURTEEN_BIT_ENABLE_SYNC(32'h1fffe800)) u_rcm_top (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .serial_mode(serial_mode),
      .pin_clock_mode_sel(pin_cm), .pin_ref_crystal_select(pin_ref),
      .pin_ratio_sel(pin_ratio), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
      .rx_frame(rx_frame), .rx_data(rx_data), .aux_data_in(aux),
      .cs_rate_code(cs), .pll_clk(pll_clk), .crystal_in(xd[1]),
      .master_clock_out_a(mca), .master_clock_out_b(mcb), .serial_data_out(sdo),
      .high_rate_indicator(hri), .pll_unlocked(unl), .pll_enable(pll_en),
      .crystal_enable(xtal_en), .nonpcm_detected(npcm), .dts_stream_flag(dts),
      .rate_code(rate));
   rcm_tx_model u_rcm_tx_model (.aclk(aclk), .frame_cyc(frame_cyc), .rx_word(rx_word),
      .rx_word_valid(rx_word_valid), .rx_frame(rx_frame), .rx_data(rx_data),
      .pll_clk(pll_clk));
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // crystal at half the recovered rate
   always @(posedge aclk)
   begin
      xd <= xd + 2'd1;
      cyc <= cyc + 1;
      pa <= mca;
      pb <= mcb;
      if (mca !== pa)
         ca <= ca + 1;
      if (mcb !== pb)
         cb <= cb + 1;
      if (cyc == 90000)
      begin
         n_mismatch++;
         complete_run;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_d;
      logic w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_d && w_d))
      begin
         @(posedge aclk);
         if (!aw_d && awready === 1'b1)
         begin
            aw_d = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_d && wready === 1'b1)
         begin
            w_d = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_wr
   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd
   task win(output int da, output int db);
      int a0;
      int b0;
      repeat (8) @(posedge aclk);
      a0 = ca;
      b0 = cb;
      repeat (32) @(posedge aclk);
      da = ca - a0;
      db = cb - b0;
   endtask : win
   task wait_lock(input logic v, input int n);
      repeat (n) if (unl !== v) @(posedge aclk);
   endtask : wait_lock
   task frames(input int n);
      repeat (n) do @(posedge aclk); while (rx_frame !== 1'b1);
   endtask : frames
   task send(input logic [15:0] a, input logic [15:0] b);
      u_rcm_tx_model.send_word(a);
      u_rcm_tx_model.send_word(b);
      @(posedge aclk);
   endtask : send
   ////////////////////////////////////////////////////////////////////////////
   task t_regs;
      logic [31:0] d;
      logic [1:0] r;
      int da, db, db2;
      axi_rd(OFS_CTRL, d, r);
      chk(d, {21'h0, CTRL_RST});
      chk(xtal_en, 1'b0);
      wait_lock(1'b0, 4000);
      chk(unl, 1'b0);
      chk(rate, 4'h3);
      axi_rd(8'h0c, d, r);
      chk(r, RESP_SLVERR);
      axi_wr(OFS_STATUS, 32'hffffffff, r);
      chk(r, RESP_OKAY);
      axi_wr(8'h10, 32'h0, r);
      chk(r, RESP_SLVERR);
      axi_wr(OFS_CTRL, 32'h00000311, r);
      axi_rd(OFS_CTRL, d, r);
      chk(d, 32'h00000311);
      win(da, db);
      chk(pll_en, 1'b0);
      chk(sdo, 1'b1);
      chk(xtal_en, 1'b1);
      chk(db != 0, 1'b1);
      chk(da != 0, 1'b1);
      axi_wr(OFS_CTRL, 32'h00000331, r);
      win(da, db2);
      chk(db2 < db && db2 != 0, 1'b1);
   endtask : t_regs
   task t_dts;
      send(16'h7ffe, 16'h8001);
      chk(dts, 1'b0);
      send(16'h1fff, 16'he800);
      chk(dts, 1'b1);
   endtask : t_dts
   task t_modes;
      int da, db;
      serial_mode <= 1'b0;
      wait_lock(1'b0, 600);
      chk(unl, 1'b0);
      win(da, db);
      chk(sdo, 1'b0);
      chk(db, 0);
      chk(da != 0, 1'b1);
      pin_cm <= 2'b10;
      win(da, db);
      chk(db, 0);
      frame_cyc <= 16'd13;
      wait_lock(1'b1, 60);
      chk(unl, 1'b1);
      win(da, db);
      chk(sdo, 1'b1);
      chk(db != 0, 1'b1);
      pin_cm <= 2'b11;
      win(da, db);
      chk(pll_en, 1'b1);
      chk(sdo, 1'b1);
      pin_cm <= 2'b00;
      frame_cyc <= 16'd8;
   endtask : t_modes
   task t_npcm;
      logic [31:0] d;
      logic [1:0] r;
      send(16'h0000, 16'h0000);
      send(16'h0000, 16'h0000);
      send(16'hf872, 16'h4e1f);
      chk(npcm, 1'b1);
      send(16'h0015, 16'h1234);
      axi_rd(OFS_BURST, d, r);
      chk(d, 32'h12340015);
      frames(4000);
      chk(npcm, 1'b1);
      frames(120);
      chk(npcm, 1'b0);
      send(16'h0001, 16'h0000);
      send(16'h0000, 16'h0000);
      send(16'hf872, 16'h4e1f);
      chk(npcm, 1'b0);
   endtask : t_npcm
   task t_rate;
      int da, db;
      chk(dts, 1'b0);
      send(16'h7ffe, 16'h8001);
      chk(dts, 1'b1);
      frame_cyc <= 16'd5208;
      frames(4);
      chk(hri, 1'b0);
      chk(rate, 4'h2);
      frame_cyc <= 16'd2604;
      frames(4);
      chk(hri, 1'b1);
      chk(rate, RATE_96K);
      pin_ratio <= 2'b10;
      win(da, db);
      chk(da, 0);
      pin_ratio <= 2'b11;
      win(da, db);
      chk(da != 0, 1'b1);
   endtask : t_rate
   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, pin_cm, pin_ratio} = '0;
      {awaddr, araddr, wdata, xd, pa, pb} = '0;
      wstrb = 4'hf;
      serial_mode = 1'b1;
      aux = 1'b1;
      cs = 4'h3;
      pin_ref = 2'b10;
      frame_cyc = 16'd8;
      {n_mismatch, samples_checked, cyc, ca, cb} = '0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_dts;
      t_modes;
      t_npcm;
      t_rate;
      complete_run;
   end
endmodule : testbench
`default_nettype wire
